// >>> design/irq_status_wdt.sv
// Interrupt status, mask and watchdog timer register block
//
// Overview of operation
// [RQ1] Fourteen flag, read-only status register, resets zero
// [RQ2] Reading status returns flags then clears them
// [RQ3] Unmasked set flag drives interrupt output high
// [RQ4] HDLC channel interrupt sets HDLC flag
// [RQ5] Command/indicate receive event sets its flag
// [RQ6] Receive monitor channel event sets flag
// [RQ7] Transmit monitor channel event sets flag
// [RQ8] Any circular queue full sets flag
// [RQ9] FIFO three quarters full sets warning
// [RQ10] FIFO full and stalled sets overload
// [RQ11] Timer period interrupt sets period flag
// [RQ12] Sequence analyzer recovery sets recovered flag
// [RQ13] Fault counter reaching 255 sets flag
// [RQ14] Mask resets all ones; set bit masks
// [RQ15] Mask bit n gates status flag n
// [RQ16] Period register: seconds, millis, sub-millis fields
// [RQ17] Expired period without restart raises watchdog output
// [RQ18] Each period end raises period flag
// [RQ19] Timebase select picks frame sync or clock
// [RQ20] Time stamping enabled ignores period register
// [RQ21] Event during clearing read stays set
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module irq_status_wdt #(
   parameter int TICK_CLKS = irq_wdt_pkg::TICK_CLKS
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   // Event sources, one-cycle pulses, plus the fault counter value
   input  wire logic        hdlc_event,
   input  wire logic        cmd_ind_rx_event,
   input  wire logic        monitor_rx_event,
   input  wire logic        monitor_tx_event,
   input  wire logic        circular_queue_full,
   input  wire logic        rx_fifo_warning,
   input  wire logic        rx_fifo_overload,
   input  wire logic        tx_fifo_warning,
   input  wire logic        tx_fifo_overload,
   input  wire logic        event_fifo_warning,
   input  wire logic        event_fifo_overload,
   input  wire logic        sequence_recovered,
   input  wire logic [7:0]  fault_count,
   // Timer control bits held elsewhere
   input  wire logic        watchdog_restart_bit,
   input  wire logic        timebase_select,
   input  wire logic        timestamp_enable,
   input  wire logic        frame_sync,
   // Outputs
   output logic             irq_out,
   output logic             watchdog_out
);

   timer_if tif ();

   logic [13:0] status_q;
   logic [13:0] events;
   logic [15:0] mask_q;
   logic [15:0] period_q;
   logic [15:0] rdata_q;
   logic [7:0]  fault_prev_q;
   logic        fault_full;
   logic        frame_q;
   logic        status_rd;

   // Fault counter arrival at full value, edge only
   assign fault_full = fault_count == irq_wdt_pkg::FAULT_COUNT_FULL
      && fault_prev_q != irq_wdt_pkg::FAULT_COUNT_FULL;  // [RQ13]

   // Previous fault counter value
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         fault_prev_q <= 8'h00;
      else
         fault_prev_q <= fault_count;
   end

   // Gather event pulses into flag positions
   always_comb
   begin
      events = 14'h0000;
      events[irq_wdt_pkg::BIT_HDLC]                = hdlc_event;       // [RQ4]
      events[irq_wdt_pkg::BIT_CMD_IND_RX]          = cmd_ind_rx_event; // [RQ5]
      events[irq_wdt_pkg::BIT_MONITOR_RX]          = monitor_rx_event; // [RQ6]
      events[irq_wdt_pkg::BIT_MONITOR_TX]          = monitor_tx_event; // [RQ7]
      events[irq_wdt_pkg::BIT_CIRCULAR_QUEUE_FULL] = circular_queue_full;
      // Circular queue full above        [RQ8]
      events[irq_wdt_pkg::BIT_RX_FIFO_WARNING]     = rx_fifo_warning;  // [RQ9]
      events[irq_wdt_pkg::BIT_TX_FIFO_WARNING]     = tx_fifo_warning;  // [RQ9]
      events[irq_wdt_pkg::BIT_EVENT_FIFO_WARNING]  = event_fifo_warning;
      events[irq_wdt_pkg::BIT_RX_FIFO_OVERLOAD]    = rx_fifo_overload;
      events[irq_wdt_pkg::BIT_TX_FIFO_OVERLOAD]    = tx_fifo_overload;
      events[irq_wdt_pkg::BIT_EVENT_FIFO_OVERLOAD] = event_fifo_overload;
      // FIFO overloads above              [RQ10]
      events[irq_wdt_pkg::BIT_PERIOD]              = tif.period_end;   // [RQ11]
      events[irq_wdt_pkg::BIT_SEQUENCE_RECOVERED]  = sequence_recovered;
      // Sequence recovery above           [RQ12]
      events[irq_wdt_pkg::BIT_FAULT_COUNTER_FULL]  = fault_full;
   end

   assign status_rd = rd && addr == irq_wdt_pkg::OFF_INTERRUPT_STATUS;

   // Sticky flags, set beats clear-on-read
   for (genvar i = 0; i < irq_wdt_pkg::NUM_FLAGS; i++)
   begin : g_flag
      always_ff @(posedge clk or posedge reset)
      begin
         if (reset)
            status_q[i] <= irq_wdt_pkg::RST_INTERRUPT_STATUS[i];  // [RQ1]
         else if (events[i])
            status_q[i] <= 1'b1;                                  // [RQ21]
         else if (status_rd)
            status_q[i] <= 1'b0;                                  // [RQ2]
      end
   end

   // Mask register
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         mask_q <= irq_wdt_pkg::RST_INTERRUPT_MASK;               // [RQ14]
      else if (wr && addr == irq_wdt_pkg::OFF_INTERRUPT_MASK)
         mask_q <= wdata;
   end

   // Watchdog period register
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         period_q <= irq_wdt_pkg::RST_WATCHDOG_PERIOD;            // [RQ16]
      else if (wr && addr == irq_wdt_pkg::OFF_WATCHDOG_PERIOD)
         period_q <= wdata;
   end

   // Read data, valid the cycle after the strobe
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rdata_q <= 16'h0000;
      else if (rd)
      begin
         unique case (addr)
            irq_wdt_pkg::OFF_INTERRUPT_STATUS:
               rdata_q <= {2'b00, status_q};                      // [RQ2]
            irq_wdt_pkg::OFF_INTERRUPT_MASK:
               rdata_q <= mask_q;
            irq_wdt_pkg::OFF_WATCHDOG_PERIOD:
               rdata_q <= period_q;
            default:
               rdata_q <= 16'h0000;
         endcase
      end
      else
         rdata_q <= 16'h0000;
   end

   assign rdata = rdata_q;

   // Unmasked flags onto the interrupt line
   assign irq_out = |(status_q & ~mask_q[13:0]);                 // [RQ3] [RQ15]

   // Frame sync edge detection
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         frame_q <= 1'b0;
      else
         frame_q <= frame_sync;
   end

   // Timer hookup
   assign tif.period_cfg   = period_q;
   assign tif.restart      = watchdog_restart_bit;               // [RQ17]
   assign tif.timebase_sel = timebase_select;                    // [RQ19]
   assign tif.frame_edge   = frame_sync && !frame_q;
   assign tif.halt         = timestamp_enable;                   // [RQ20]

   period_timer #(
      .TICK_CLKS (TICK_CLKS)
   ) u_timer (
      .clk   (clk),
      .reset (reset),
      .tif   (tif.timer)
   );

   assign watchdog_out = tif.wd_trip;                            // [RQ17]

endmodule : irq_status_wdt

// >>> design/irq_wdt_pkg.sv
// Constants for the interrupt status and watchdog timer block
package irq_wdt_pkg;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // Register offsets
   localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h38;
   localparam logic [7:0] OFF_INTERRUPT_MASK   = 8'h3A;
   localparam logic [7:0] OFF_WATCHDOG_PERIOD  = 8'h3C;
   localparam logic [7:0] OFF_FACTORY_TEST     = 8'h3E;

   // Reset values
   localparam logic [15:0] RST_INTERRUPT_STATUS = 16'h0000;
   localparam logic [15:0] RST_INTERRUPT_MASK   = 16'hFFFF;
   localparam logic [15:0] RST_WATCHDOG_PERIOD  = 16'h0800;

   // Status flag positions
   localparam int NUM_FLAGS               = 14;
   localparam int BIT_HDLC                = 0;
   localparam int BIT_CMD_IND_RX          = 1;
   localparam int BIT_MONITOR_RX          = 2;
   localparam int BIT_MONITOR_TX          = 3;
   localparam int BIT_CIRCULAR_QUEUE_FULL = 4;
   localparam int BIT_RX_FIFO_WARNING     = 5;
   localparam int BIT_RX_FIFO_OVERLOAD    = 6;
   localparam int BIT_TX_FIFO_WARNING     = 7;
   localparam int BIT_TX_FIFO_OVERLOAD    = 8;
   localparam int BIT_EVENT_FIFO_WARNING  = 9;
   localparam int BIT_EVENT_FIFO_OVERLOAD = 10;
   localparam int BIT_PERIOD              = 11;
   localparam int BIT_SEQUENCE_RECOVERED  = 12;
   localparam int BIT_FAULT_COUNTER_FULL  = 13;

   // Watchdog period field layout
   localparam int SECONDS_MSB = 15;
   localparam int SECONDS_LSB = 12;
   localparam int MILLIS_MSB  = 11;
   localparam int MILLIS_LSB  = 2;
   localparam int SUB_MSB     = 1;
   localparam int SUB_LSB     = 0;

   // Fault counter full value
   localparam logic [7:0] FAULT_COUNT_FULL = 8'hFF;

   // Timing: the period counts quarter milliseconds
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_NS       = 250000;
   localparam int FRAME_NS      = 125000;
   localparam int TICK_CLKS     = TICK_NS / CLK_PERIOD_NS;
   localparam int FRAMES_PER_TICK = TICK_NS / FRAME_NS;
   localparam logic [15:0] TICKS_PER_SECOND = 16'h0FA0;

endpackage : irq_wdt_pkg

// >>> design/period_timer.sv
// Watchdog and periodic time base counter
`timescale 1ns/10ps
module period_timer #(
   parameter int TICK_CLKS = irq_wdt_pkg::TICK_CLKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register side
   timer_if.timer   tif
);

   logic [15:0] period_ticks;
   logic [15:0] presc_q;
   logic [3:0]  frames_q;
   logic        tick;
   logic [15:0] count_q;
   logic        end_q;
   logic        trip_q;
   logic        reached;

   // Period in quarter milliseconds from the three fields
   assign period_ticks =
      16'({12'h000, tif.period_cfg[irq_wdt_pkg::SECONDS_MSB:
                                   irq_wdt_pkg::SECONDS_LSB]}
          * irq_wdt_pkg::TICKS_PER_SECOND)
      + {4'h0, tif.period_cfg[irq_wdt_pkg::MILLIS_MSB:
                              irq_wdt_pkg::MILLIS_LSB], 2'b00}
      + {14'h0000, tif.period_cfg[irq_wdt_pkg::SUB_MSB:
                                  irq_wdt_pkg::SUB_LSB]};

   // Tick from frame sync edges or divided master clock
   assign tick = tif.timebase_sel
      ? (tif.frame_edge &&
         frames_q == 4'(irq_wdt_pkg::FRAMES_PER_TICK - 1))
      : (presc_q == 16'(TICK_CLKS - 1));                  // [RQ19]

   // Master clock prescaler
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         presc_q <= 16'h0000;
      else if (tif.restart || tif.timebase_sel || tick)
         presc_q <= 16'h0000;
      else
         presc_q <= presc_q + 16'h0001;
   end

   // Frame edge divider
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         frames_q <= 4'h0;
      else if (tif.restart || !tif.timebase_sel || tick)
         frames_q <= 4'h0;
      else if (tif.frame_edge)
         frames_q <= frames_q + 4'h1;
   end

   assign reached = tick && (count_q + 16'h0001 >= period_ticks)
                    && period_ticks != 16'h0000;

   // Period counter, restart wins over expiry
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         count_q <= 16'h0000;
      else if (tif.restart || tif.halt || reached)       // [RQ20]
         count_q <= 16'h0000;
      else if (tick)
         count_q <= count_q + 16'h0001;
   end

   // One-cycle period end pulse
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         end_q <= 1'b0;
      else
         end_q <= reached && !tif.restart && !tif.halt;  // [RQ18]
   end

   // Watchdog level until restarted
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         trip_q <= 1'b0;
      else if (tif.restart)
         trip_q <= 1'b0;
      else if (reached && !tif.halt)
         trip_q <= 1'b1;                                 // [RQ17]
   end

   assign tif.period_end = end_q;
   assign tif.wd_trip    = trip_q;

endmodule : period_timer

// >>> design/timer_if.sv
// Link between register logic and the period timer
`timescale 1ns/10ps
interface timer_if;
   logic [15:0] period_cfg;
   logic        restart;
   logic        timebase_sel;
   logic        frame_edge;
   logic        halt;
   logic        period_end;
   logic        wd_trip;

   // Register side
   modport ctrl (
      output period_cfg,
      output restart,
      output timebase_sel,
      output frame_edge,
      output halt,
      input  period_end,
      input  wd_trip
   );

   // Timer side
   modport timer (
      input  period_cfg,
      input  restart,
      input  timebase_sel,
      input  frame_edge,
      input  halt,
      output period_end,
      output wd_trip
   );
endinterface : timer_if

// >>> verification/host_model.sv
// Host model: register bus master and watchdog service
`timescale 1ns/10ps
module host_model (
   // Clock and read data
   input  wire logic        clk,
   input  wire logic [15:0] rdata,
   // Register bus and restart
   output logic      [7:0]  addr,
   output logic      [15:0] wdata,
   output logic             wr,
   output logic             rd,
   output logic             restart
);
   // Idle bus at time zero
   initial
   begin
      {addr, wdata, wr, rd, restart} = '0;
   end
   // One-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      wdata <= ~d;
   endtask : wr_reg
   // One-cycle read strobe, data taken in the next cycle
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   // Watchdog service pulse
   task automatic kick();
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
   endtask : kick
endmodule : host_model

// >>> verification/irq_status_wdt_sva.sv
// Port assertions for the status and watchdog block
`timescale 1ns/10ps
module irq_status_wdt_sva (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Register port
   input wire logic [7:0]  addr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   // Events and timer controls
   input wire logic        hdlc_event,
   input wire logic        sequence_recovered,
   input wire logic [7:0]  fault_count,
   input wire logic        watchdog_restart_bit,
   input wire logic        timestamp_enable,
   input wire logic        watchdog_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Status read strobe
   wire status_rd = rd && addr == 8'h38;

   chk_rdata_idle: assert property (
      !$past(rd) |-> rdata == 16'h0000) else $error("stray read data");
   chk_status_top: assert property (
      status_rd |=> rdata[15:14] == 2'h0) else $error("unused bits set");
   chk_test_zero: assert property (
      rd && addr == 8'h3E |=> rdata == 16'h0000) else $error("test read");
   chk_hdlc_sets: assert property (
      hdlc_event ##1 !rd ##1 status_rd |=> rdata[0])
      else $error("event flag lost");
   chk_read_clears: assert property (
      (status_rd && !hdlc_event) ##1 (!rd && !hdlc_event) ##1 status_rd
      |=> !rdata[0]) else $error("flag not cleared by read");
   chk_race_keeps: assert property (
      (status_rd && sequence_recovered) ##1 !rd ##1 status_rd |=> rdata[12])
      else $error("event lost in clearing read");
   chk_fault_full: assert property (
      (fault_count == 8'hFF && $past(fault_count) != 8'hFF) ##1 !rd
      ##1 status_rd |=> rdata[13]) else $error("fault flag missing");
   chk_restart_clr: assert property (
      watchdog_restart_bit |=> !watchdog_out) else $error("restart ignored");
   chk_trip_holds: assert property (
      watchdog_out && !watchdog_restart_bit |=> watchdog_out)
      else $error("watchdog output dropped");
   chk_halt_trip: assert property (
      timestamp_enable [*3] |-> !$rose(watchdog_out))
      else $error("trip while halted");
endmodule : irq_status_wdt_sva

bind irq_status_wdt irq_status_wdt_sva irq_status_wdt_sva_inst (
   .clk(clk), .reset(reset), .addr(addr), .rd(rd), .rdata(rdata),
   .hdlc_event(hdlc_event), .sequence_recovered(sequence_recovered),
   .fault_count(fault_count), .watchdog_restart_bit(watchdog_restart_bit),
   .timestamp_enable(timestamp_enable), .watchdog_out(watchdog_out));

// >>> verification/tb_irq_status_wdt.sv
// Self-checking bench for the status and watchdog block
`timescale 1ns/10ps
module tb_irq_status_wdt;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata, got;
   logic        wr, rd, restart, irq_out, watchdog_out;
   logic [13:0] ev_q = '0;
   logic        tbs = 1'b0, ts_en = 1'b1, frame = 1'b0, fr_on = 1'b0;
   int          failures = 0, n_tests = 0, n;

   // Clock and frame sync, still while off
   always #25 clk = ~clk;
   always @(posedge clk) frame <= fr_on ? ~frame : 1'b0;

   irq_status_wdt #(.TICK_CLKS(2)) irq_status_wdt_inst (
      .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .hdlc_event(ev_q[0]),
      .cmd_ind_rx_event(ev_q[1]), .monitor_rx_event(ev_q[2]),
      .monitor_tx_event(ev_q[3]), .circular_queue_full(ev_q[4]),
      .rx_fifo_warning(ev_q[5]), .rx_fifo_overload(ev_q[6]),
      .tx_fifo_warning(ev_q[7]), .tx_fifo_overload(ev_q[8]),
      .event_fifo_warning(ev_q[9]), .event_fifo_overload(ev_q[10]),
      .sequence_recovered(ev_q[12]), .fault_count({8{ev_q[13]}}),
      .watchdog_restart_bit(restart), .timebase_select(tbs),
      .timestamp_enable(ts_en), .frame_sync(frame), .irq_out(irq_out),
      .watchdog_out(watchdog_out));

   host_model host_model_inst (
      .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .restart(restart));

   // Compare and count
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Read a register and compare
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      host_model_inst.rd_reg(a, d);
      chk(d, e);
   endtask : rdchk
   // One-cycle event pulse
   task automatic pulse(input int b);
      @(posedge clk);
      ev_q[b] <= 1'b1;
      @(posedge clk);
      ev_q[b] <= 1'b0;
      #1;
   endtask : pulse
   // Clocks until the watchdog output rises
   task automatic wait_trip(output int c);
      c = 0;
      while (watchdog_out !== 1'b1 && c < 60)
      begin
         @(posedge clk);
         #1 c = c + 1;
      end
   endtask : wait_trip

   task automatic t_regs();
      rdchk(8'h38, 16'h0000);
      rdchk(8'h3A, 16'hFFFF);
      rdchk(8'h3C, 16'h0800);
      rdchk(8'h50, 16'h0000);
      host_model_inst.wr_reg(8'h38, 16'hFFFF);
      host_model_inst.wr_reg(8'h3E, 16'h1234);
      rdchk(8'h38, 16'h0000);
      rdchk(8'h3E, 16'h0000);
      host_model_inst.wr_reg(8'h3C, 16'hA5A5);
      rdchk(8'h3C, 16'hA5A5);
      $display("Test registers done");
   endtask : t_regs

   task automatic t_flags();
      for (int b = 0; b < 14; b++)
      begin
         if (b == 11)
            continue;
         host_model_inst.wr_reg(8'h3A, 16'h0001 << b);
         pulse(b);
         chk({15'h0000, irq_out}, 16'h0000);
         rdchk(8'h38, 16'h0001 << b);
         host_model_inst.wr_reg(8'h3A, 16'h0000);
         pulse(b);
         chk({15'h0000, irq_out}, 16'h0001);
         rdchk(8'h38, 16'h0001 << b);
         chk({15'h0000, irq_out}, 16'h0000);
      end
      fork
         host_model_inst.rd_reg(8'h38, got);
         pulse(12);
      join
      chk(got, 16'h0000);
      rdchk(8'h38, 16'h1000);
      $display("Test flags done");
   endtask : t_flags

   task automatic t_timer();
      host_model_inst.wr_reg(8'h3C, 16'h0002);
      ts_en <= 1'b0;
      host_model_inst.kick();
      wait_trip(n);
      chk(16'(n >= 3 && n <= 8), 16'h0001);
      rdchk(8'h38, 16'h0800);
      repeat (15) host_model_inst.kick();
      chk({15'h0000, watchdog_out}, 16'h0000);
      // Millis plus sub field: five ticks of two clocks each
      host_model_inst.wr_reg(8'h3C, 16'h0005);
      host_model_inst.kick();
      wait_trip(n);
      chk(16'(n), 16'h000A);
      host_model_inst.wr_reg(8'h3C, 16'h0002);
      @(posedge clk);
      tbs <= 1'b1;
      host_model_inst.kick();
      repeat (20) @(posedge clk);
      chk({15'h0000, watchdog_out}, 16'h0000);
      fr_on <= 1'b1;
      wait_trip(n);
      chk(16'(n >= 6 && n <= 12), 16'h0001);
      @(posedge clk);
      fr_on <= 1'b0;
      tbs   <= 1'b0;
      ts_en <= 1'b1;
      host_model_inst.kick();
      repeat (40) @(posedge clk);
      chk({15'h0000, watchdog_out}, 16'h0000);
      $display("Test timer done");
   endtask : t_timer

   // Verdict and end of run
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_flags();
      t_timer();
      final_report();
   end
   // Watchdog on the run
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule : tb_irq_status_wdt
